// >>> core/ulf_uart_lin.v
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ulf_consts.vh"
module ulf_uart_lin (
  // Clock and reset
  input wire CLK,
  input wire SYS_RST,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Serial line
  input wire RX_IN,
  output reg TX_OUT,
  // Event levels
  output reg RX_READY_IRQ,
  output reg TX_READY_IRQ,
  output reg FRAMING_ERR_IRQ
);
  // ----------------------------------------
  // Checksum add with end-around carry
  // ----------------------------------------
  function [7:0] ck_add;
    input [7:0] a;
    input [7:0] b;
    reg [8:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      ck_add = s[7:0] + {7'h00, s[8]};
    end
  endfunction

  localparam [4:0] TX_IDLE = 5'h01;
  localparam [4:0] TX_BRK = 5'h02;
  localparam [4:0] TX_START = 5'h04;
  localparam [4:0] TX_DATA = 5'h08;
  localparam [4:0] TX_STOP = 5'h10;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [11:0] ctrl_q;
  reg [15:0] baud_q;
  reg [8:0] p3_q;
  reg dly_sel_q, tx_write_error_q, ferr_q, cerr_q, ovf_q;
  reg [7:0] rxm_q [0:1];
  reg rx_wp_q, rx_rp_q;
  reg [1:0] rx_cnt_q;
  reg rx_hold_q;
  reg [7:0] tsr_q, txb_q;
  reg tsr_full_q, txb_full_q;
  reg [4:0] tx_st_q;
  reg [4:0] tx_h_q;
  reg [3:0] tx_bits_q;
  reg [15:0] tx_div_q;
  reg [7:0] tx_sh_q;
  reg [1:0] lin_tph_q;
  reg [7:0] tx_ck_q, tx_dcnt_q;
  reg rx_act_q, rx_prev_q, rx_wferr_q;
  reg [4:0] rx_h_q;
  reg [15:0] rx_div_q;
  reg [7:0] rx_sh_q;
  reg [1:0] lin_rph_q;
  reg [7:0] rx_ck_q, rx_pid_q, rx_dcnt_q;

  wire on = ctrl_q[`ULF_C_ON];
  wire tx_en = ctrl_q[`ULF_C_TX_ENABLE_BIT];
  wire rx_en = ctrl_q[`ULF_C_RX_ENABLE_BIT];
  wire lin = ctrl_q[`ULF_C_MODE_HI:`ULF_C_MODE_LO] == `ULF_MODE_LIN;
  wire [1:0] stop_bit_sel = ctrl_q[`ULF_C_STP_HI:`ULF_C_STP_LO];
  wire ck_enh = ctrl_q[`ULF_C_CKM];
  wire run_ovf = ctrl_q[`ULF_C_RUN_ON_OVERFLOW];
  wire [15:0] half = (baud_q[15:2] == 14'h0000) ? 16'h0002 : {1'b0, baud_q[15:1]};
  // Stop length in half bits: 1, 1.5, 2, 2 bits
  wire [4:0] stop_halves = (stop_bit_sel == 2'h0) ? 5'h02 : (stop_bit_sel == 2'h1) ? 5'h03 : 5'h04;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire setup = PSEL & ~PENABLE;
  wire acc = PSEL & PENABLE & PREADY;
  wire wr = acc & PWRITE;
  wire rd = acc & ~PWRITE;
  wire hit = (PADDR == `ULF_OFF_CTRL) || (PADDR == `ULF_OFF_BAUD) || (PADDR == `ULF_OFF_STAT) ||
    (PADDR == `ULF_OFF_RXD) || (PADDR == `ULF_OFF_TXD) || (PADDR == `ULF_OFF_P3L) ||
    (PADDR == `ULF_OFF_P3H);
  wire wr_stat = wr && (PADDR == `ULF_OFF_STAT);
  wire wr_tx = wr && (PADDR == `ULF_OFF_TXD);
  wire rd_rx = rd && (PADDR == `ULF_OFF_RXD);
  wire rx_flush = wr_stat && PWDATA[`ULF_S_RX_BUF_EMPTY];
  wire tx_flush = wr_stat && PWDATA[`ULF_S_TX_BUF_EMPTY];
  wire rx_empty = ~RX_READY_IRQ;
  wire [31:0] stat_word = {22'h000000, ovf_q, cerr_q, 1'b0, ferr_q, dly_sel_q, tx_write_error_q,
    txb_full_q, ~txb_full_q, rx_cnt_q == 2'h2, rx_empty};

  reg [31:0] rd_word;
  always @* begin
    rd_word = 32'h00000000;
    if (PADDR == `ULF_OFF_CTRL) begin
      rd_word = {20'h00000, ctrl_q};
    end else if (PADDR == `ULF_OFF_BAUD) begin
      rd_word = {16'h0000, baud_q};
    end else if (PADDR == `ULF_OFF_STAT) begin
      rd_word = stat_word;
    end else if (PADDR == `ULF_OFF_RXD) begin
      rd_word = {24'h000000, rx_cnt_q != 2'h0 ? rxm_q[rx_rp_q] : 8'h00};
    end else if (PADDR == `ULF_OFF_P3L) begin
      rd_word = {24'h000000, p3_q[7:0]};
    end else if (PADDR == `ULF_OFF_P3H) begin
      rd_word = {31'h00000000, p3_q[8]};
    end
  end

  // Zero wait states: answer is prepared in the setup cycle
  always @(posedge CLK) begin
    if (SYS_RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= setup;
      if (setup) begin
        PRDATA <= PWRITE ? 32'h00000000 : rd_word;
        PSLVERR <= ~hit;
      end else if (acc) begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Receive engine
  // ----------------------------------------
  wire rx_halt = ovf_q & ~run_ovf;
  wire rx_run = on & rx_en & ~rx_halt;
  wire rx_tick = rx_run & rx_act_q & (rx_div_q == half - 16'h0001);
  wire [4:0] rx_hn = rx_h_q + 5'h01;
  wire rx_chk = rx_tick && ((rx_hn == 5'h13) || (rx_hn == 5'h15 && stop_bit_sel == `ULF_STP_TWO_BOTH));
  wire rx_store = rx_tick && ((rx_hn == 5'h13 && stop_bit_sel != `ULF_STP_TWO_BOTH) ||
    (rx_hn == 5'h15 && stop_bit_sel == `ULF_STP_TWO_BOTH));
  wire rx_end = rx_tick && (rx_hn == 5'h12 + stop_halves);
  wire word_ferr = rx_wferr_q | (rx_chk & ~RX_IN);
  wire rx_push = rx_store && rx_cnt_q != 2'h2;
  wire rx_pop = rd_rx && rx_cnt_q != 2'h0;

  always @(posedge CLK) begin
    if (SYS_RST || !on) begin
      rx_act_q <= 1'b0;
      rx_prev_q <= 1'b1;
      rx_h_q <= 5'h00;
      rx_div_q <= 16'h0000;
      rx_sh_q <= 8'h00;
      rx_wferr_q <= 1'b0;
    end else if (rx_run) begin
      rx_prev_q <= RX_IN;
      if (!rx_act_q) begin
        if (rx_prev_q && !RX_IN) begin
          rx_act_q <= 1'b1;
          rx_h_q <= 5'h00;
          rx_div_q <= 16'h0000;
          rx_wferr_q <= 1'b0;
        end
      end else if (rx_tick) begin
        rx_div_q <= 16'h0000;
        rx_h_q <= rx_hn;
        if (rx_hn == 5'h01 && RX_IN) begin
          rx_act_q <= 1'b0;
        end
        if (rx_hn[0] && rx_hn >= 5'h03 && rx_hn <= 5'h11) begin
          rx_sh_q <= {RX_IN, rx_sh_q[7:1]};
        end
        if (rx_chk && !RX_IN) begin
          rx_wferr_q <= 1'b1;
        end
        if (rx_end) begin
          rx_act_q <= 1'b0;
        end
      end else begin
        rx_div_q <= rx_div_q + 16'h0001;
      end
    end
  end

  // Two-entry receive buffer
  always @(posedge CLK) begin
    if (SYS_RST || !on || rx_flush) begin
      rx_wp_q <= 1'b0;
      rx_rp_q <= 1'b0;
      rx_cnt_q <= 2'h0;
      rx_hold_q <= 1'b0;
    end else begin
      if (rx_push) begin
        rxm_q[rx_wp_q] <= rx_sh_q;
        rx_wp_q <= ~rx_wp_q;
      end
      if (rx_pop) begin
        rx_rp_q <= ~rx_rp_q;
      end
      rx_cnt_q <= rx_cnt_q + {1'b0, rx_push} - {1'b0, rx_pop};
      if (rx_push && dly_sel_q) begin
        rx_hold_q <= 1'b1;
      end else if (rx_end || !rx_act_q) begin
        rx_hold_q <= 1'b0;
      end
    end
  end

  // Newest byte hidden until end of stop while delayed
  wire [1:0] rx_vis = rx_cnt_q - {1'b0, rx_hold_q};
  always @(posedge CLK) begin
    if (SYS_RST) begin
      RX_READY_IRQ <= 1'b0;
      TX_READY_IRQ <= 1'b1;
      FRAMING_ERR_IRQ <= 1'b0;
    end else begin
      RX_READY_IRQ <= (rx_vis != 2'h0) && !rx_flush && on;
      TX_READY_IRQ <= ~txb_full_q;
      FRAMING_ERR_IRQ <= ferr_q;
    end
  end

  // ----------------------------------------
  // LIN receive checksum
  // ----------------------------------------
  wire [7:0] rx_pid_term = ck_enh ? rx_pid_q : 8'h00;
  wire [7:0] rx_total = ck_add(ck_add(rx_ck_q, rx_pid_term), rx_sh_q);
  wire rx_ck_bad = rx_store && lin && lin_rph_q == 2'h3 && rx_dcnt_q == p3_q[7:0] && rx_total != 8'hFF;

  always @(posedge CLK) begin
    if (SYS_RST || !on || !lin) begin
      lin_rph_q <= 2'h0;
      rx_ck_q <= 8'h00;
      rx_pid_q <= 8'h00;
      rx_dcnt_q <= 8'h00;
    end else if (rx_store) begin
      if (rx_sh_q == 8'h00 && word_ferr) begin
        lin_rph_q <= 2'h1;
      end else if (lin_rph_q == 2'h1) begin
        lin_rph_q <= 2'h2;
      end else if (lin_rph_q == 2'h2) begin
        rx_pid_q <= rx_sh_q;
        rx_ck_q <= 8'h00;
        rx_dcnt_q <= 8'h00;
        lin_rph_q <= 2'h3;
      end else if (lin_rph_q == 2'h3) begin
        if (rx_dcnt_q == p3_q[7:0]) begin
          lin_rph_q <= 2'h0;
        end else begin
          rx_ck_q <= ck_add(rx_ck_q, rx_sh_q);
          rx_dcnt_q <= rx_dcnt_q + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------
  // Transmit engine
  // ----------------------------------------
  wire tx_go = on & tx_en & tx_st_q[0];
  wire tx_hdr = lin && lin_tph_q == 2'h0 && tsr_full_q;
  wire tx_cks = lin && lin_tph_q == 2'h2 && !tsr_full_q && p3_q[7:0] != 8'h00 &&
    tx_dcnt_q == p3_q[7:0];
  wire tsr_take = tx_go && !tx_hdr && !tx_cks && tsr_full_q;
  wire tx_tick = !tx_st_q[0] && (tx_div_q == half - 16'h0001);
  wire [4:0] tx_hn = tx_h_q + 5'h01;

  always @(posedge CLK) begin
    if (SYS_RST || !on) begin
      tx_st_q <= TX_IDLE;
      tx_h_q <= 5'h00;
      tx_div_q <= 16'h0000;
      tx_bits_q <= 4'h0;
      tx_sh_q <= 8'h00;
      lin_tph_q <= 2'h0;
      tx_ck_q <= 8'h00;
      tx_dcnt_q <= 8'h00;
    end else begin
      tx_div_q <= (tx_st_q[0] || tx_tick) ? 16'h0000 : tx_div_q + 16'h0001;
      if (tx_tick) begin
        tx_h_q <= tx_hn;
      end
      case (tx_st_q)
        TX_IDLE: begin
          tx_h_q <= 5'h00;
          if (tx_flush || !lin) begin
            lin_tph_q <= 2'h0;
          end else if (lin_tph_q == 2'h2 && p3_q[7:0] == 8'h00) begin
            lin_tph_q <= 2'h0;
          end
          if (tx_go && tx_hdr) begin
            tx_st_q <= TX_BRK;
          end else if (tx_go && tx_cks) begin
            tx_sh_q <= ~tx_ck_q;
            lin_tph_q <= 2'h0;
            tx_st_q <= TX_START;
          end else if (tsr_take) begin
            tx_sh_q <= tsr_q;
            tx_st_q <= TX_START;
            if (lin && lin_tph_q == 2'h1) begin
              tx_ck_q <= ck_enh ? tsr_q : 8'h00;
              tx_dcnt_q <= 8'h00;
              lin_tph_q <= 2'h2;
            end else if (lin && lin_tph_q == 2'h2) begin
              tx_ck_q <= ck_add(tx_ck_q, tsr_q);
              tx_dcnt_q <= tx_dcnt_q + 8'h01;
            end
          end
        end
        TX_BRK: begin
          if (tx_tick && tx_hn == `ULF_BRKDL_HALVES) begin
            tx_sh_q <= `ULF_SYNC_BYTE;
            lin_tph_q <= 2'h1;
            tx_h_q <= 5'h00;
            tx_st_q <= TX_START;
          end
        end
        TX_START: begin
          if (tx_tick && tx_hn == `ULF_BIT_HALVES) begin
            tx_h_q <= 5'h00;
            tx_bits_q <= 4'h0;
            tx_st_q <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (tx_tick && tx_hn == `ULF_BIT_HALVES) begin
            tx_h_q <= 5'h00;
            tx_sh_q <= {1'b0, tx_sh_q[7:1]};
            tx_bits_q <= tx_bits_q + 4'h1;
            if (tx_bits_q == 4'h7) begin
              tx_st_q <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (tx_tick && tx_hn == stop_halves) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: begin
          tx_st_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Line level before polarity; delimiter follows the break low time
  reg tx_line;
  always @* begin
    tx_line = 1'b1;
    if (tx_st_q == TX_BRK) begin
      tx_line = tx_h_q >= `ULF_BRK_HALVES;
    end else if (tx_st_q == TX_START) begin
      tx_line = 1'b0;
    end else if (tx_st_q == TX_DATA) begin
      tx_line = tx_sh_q[0];
    end
  end

  always @(posedge CLK) begin
    if (SYS_RST) begin
      TX_OUT <= 1'b1;
    end else begin
      TX_OUT <= (on ? tx_line : 1'b1) ^ ctrl_q[`ULF_C_TX_POLARITY];
    end
  end

  // ----------------------------------------
  // Transmit shift register and buffer
  // ----------------------------------------
  wire tx_wr_err = wr_tx && txb_full_q;
  always @(posedge CLK) begin
    if (SYS_RST || !on || tx_flush) begin
      tsr_full_q <= 1'b0;
      txb_full_q <= 1'b0;
      tsr_q <= 8'h00;
      txb_q <= 8'h00;
    end else if (!tsr_full_q || tsr_take) begin
      if (txb_full_q) begin
        tsr_q <= txb_q;
        tsr_full_q <= 1'b1;
        txb_full_q <= 1'b0;
      end else if (wr_tx) begin
        tsr_q <= PWDATA[7:0];
        tsr_full_q <= 1'b1;
      end else begin
        tsr_full_q <= 1'b0;
      end
    end else if (wr_tx && !txb_full_q) begin
      txb_q <= PWDATA[7:0];
      txb_full_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Control and sticky flags
  // ----------------------------------------
  always @(posedge CLK) begin
    if (SYS_RST) begin
      ctrl_q <= `ULF_RST_CTRL;
      baud_q <= `ULF_RST_BAUD;
      p3_q <= `ULF_RST_P3;
      dly_sel_q <= 1'b0;
      tx_write_error_q <= 1'b0;
      ferr_q <= 1'b0;
      cerr_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      if (wr && PADDR == `ULF_OFF_CTRL) begin
        ctrl_q <= PWDATA[11:0];
      end
      if (wr && PADDR == `ULF_OFF_BAUD) begin
        baud_q <= PWDATA[15:0];
      end
      if (wr && PADDR == `ULF_OFF_P3L) begin
        p3_q[7:0] <= PWDATA[7:0];
      end
      if (wr && PADDR == `ULF_OFF_P3H) begin
        p3_q[8] <= PWDATA[0];
      end
      if (wr_stat) begin
        dly_sel_q <= PWDATA[`ULF_S_DLY];
      end
      // Set wins over a same-cycle clear
      tx_write_error_q <= tx_wr_err | (tx_write_error_q & ~(wr_stat & PWDATA[`ULF_S_TX_WRITE_ERROR]));
      ferr_q <= (rx_chk & ~RX_IN) | (ferr_q & ~(wr_stat & PWDATA[`ULF_S_FERR]));
      cerr_q <= rx_ck_bad | (cerr_q & ~(wr_stat & PWDATA[`ULF_S_CERR]));
      ovf_q <= (rx_store & ~rx_push) | (ovf_q & ~(wr_stat & PWDATA[`ULF_S_OVF]) & on);
    end
  end
endmodule // ulf_uart_lin
`default_nettype wire

// >>> include/ulf_consts.vh
// Behaviour
// - LIN master header: break, delimiter, sync, PID; then line idles.
// - Transmitting slave accumulates checksum and appends its inverse as last byte.
// - Receiving slave adds all bytes plus checksum; not all ones sets checksum error.
// - Method bit 1 includes PID (enhanced); 0 covers data bytes only.
// - In LIN mode data after the PID is slave response data.
// - Stop field: 1 verify first, 1.5 first, 2 both, 2 first only.
// - Transmitter idles the selected stop length between words.
// - Receiver checks mid stop bits; non-idle sample sets framing error.
// - Delayed bit moves receive-ready to end of last stop bit.
// - Byte stored mid second stop when field is 10, else mid first.
// - Framing errors are never delayed.
// - Run-on-overflow keeps receiver tracking; otherwise receiver halts during overflow.
// - Shift register plus two-entry receive buffer, read returns oldest.
// - Transmit write goes to empty shift register, else to single buffer.
// - Status shows receive empty, receive full, transmit empty, transmit full.
// - Transmit write while buffer full sets write error and is dropped.
// - Writing 1 to receive-empty flushes the receive buffer.
// - Disabled transmitter holds data; transmit-empty flush spares active character.
// - Turning port off discards all receive and pending transmit data.
// - LIN slave data byte count comes from parameter three low byte.
`ifndef ULF_CONSTS_VH
`define ULF_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ULF_OFF_CTRL 8'h00
`define ULF_OFF_BAUD 8'h04
`define ULF_OFF_STAT 8'h08
`define ULF_OFF_RXD 8'h0C
`define ULF_OFF_TXD 8'h10
`define ULF_OFF_P3L 8'h14
`define ULF_OFF_P3H 8'h18
// ----------------------------------------
// Control fields
// ----------------------------------------
`define ULF_C_ON 0
`define ULF_C_TX_ENABLE_BIT 1
`define ULF_C_RX_ENABLE_BIT 2
`define ULF_C_TX_POLARITY 3
`define ULF_C_MODE_LO 4
`define ULF_C_MODE_HI 7
`define ULF_C_STP_LO 8
`define ULF_C_STP_HI 9
`define ULF_C_CKM 10
`define ULF_C_RUN_ON_OVERFLOW 11
`define ULF_MODE_LIN 4'hC
`define ULF_STP_TWO_BOTH 2'h2
// ----------------------------------------
// Status fields
// ----------------------------------------
`define ULF_S_RX_BUF_EMPTY 0
`define ULF_S_RX_BUF_FULL 1
`define ULF_S_TX_BUF_EMPTY 2
`define ULF_S_TX_BUF_FULL 3
`define ULF_S_TX_WRITE_ERROR 4
`define ULF_S_DLY 5
`define ULF_S_FERR 6
`define ULF_S_CERR 8
`define ULF_S_OVF 9
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ULF_RST_CTRL 12'h000
`define ULF_RST_BAUD 16'h0364
`define ULF_RST_P3 9'h000
`define ULF_BRK_HALVES 5'h1A
`define ULF_BRKDL_HALVES 5'h1C
`define ULF_BIT_HALVES 5'h02
`define ULF_DATA_HALVES 5'h10
`define ULF_SYNC_BYTE 8'h55
`endif

// >>> verif/ulf_uart_lin_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ulf_uart_lin_sva (
  // Clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Line and events
  input wire logic RX_IN,
  input wire logic TX_OUT,
  input wire logic RX_READY_IRQ,
  input wire logic TX_READY_IRQ,
  input wire logic FRAMING_ERR_IRQ
);
  // ----
  // Decode
  // ----
  logic setup, done, rd_st, fe_clr, rx_clr;
  assign setup = PSEL && !PENABLE;
  assign done = PSEL && PENABLE && PREADY;
  assign rd_st = done && !PWRITE && PADDR == 8'h08;
  assign fe_clr = done && PWRITE && PADDR == 8'h08 && PWDATA[6];
  // Pop, flush or port off; irq is a registered copy, so allow lag
  assign rx_clr = done && (PWRITE ? (PADDR == 8'h00 || (PADDR == 8'h08 && PWDATA[0])) : PADDR == 8'h0C);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  ready_after_setup_a: assert property (setup |=> PREADY)
    else $error("ready missing after setup");
  ready_one_cycle_a: assert property (PREADY |-> $past(setup) ##1 !PREADY)
    else $error("ready not a single cycle");
  slave_err_a: assert property (done && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR > 8'h18))
    else $error("error response wrong");
  tx_flags_inv_a: assert property (rd_st |-> PRDATA[3] != PRDATA[2])
    else $error("transmit flags not inverse");
  rx_flags_excl_a: assert property (rd_st && PRDATA[1] |-> !PRDATA[0])
    else $error("receive full and empty");
  stat_zero_a: assert property (rd_st |-> PRDATA[31:10] == 22'h0 && !PRDATA[7])
    else $error("status unused bits set");
  fe_clear_a: assert property ($fell(FRAMING_ERR_IRQ) |-> $past(fe_clr) || $past(fe_clr, 2) || $past(fe_clr, 3))
    else $error("framing flag dropped alone");
  rx_drop_a: assert property ($fell(RX_READY_IRQ) |-> $past(rx_clr) || $past(rx_clr, 2) || $past(rx_clr, 3))
    else $error("receive ready dropped alone");
  reset_idle_a: assert property (disable iff (1'b0) SYS_RST |=> TX_OUT && TX_READY_IRQ && !RX_READY_IRQ && !PREADY)
    else $error("reset state wrong");
  cover property (rd_st && PRDATA[1]);
  cover property ($rose(FRAMING_ERR_IRQ));
  cover property (done && PSLVERR);
endmodule // ulf_uart_lin_sva
bind ulf_uart_lin ulf_uart_lin_sva i_sva (.CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_IN(RX_IN), .TX_OUT(TX_OUT),
  .RX_READY_IRQ(RX_READY_IRQ), .TX_READY_IRQ(TX_READY_IRQ), .FRAMING_ERR_IRQ(FRAMING_ERR_IRQ));
`default_nettype wire

// >>> verif/ulf_lin_node.sv
`timescale 1ns/100ps
`default_nettype none
module ulf_lin_node #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic clk,
  // Line
  input wire logic txd,
  output logic rxd
);
  logic [7:0] got_q[$];
  logic fe_q[$];
  logic [7:0] sh;
  // Pulled-up bus idles high
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] b, input logic s1, input logic s2);
    logic [10:0] f;
    f = {s2, s1, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (BIT) @(posedge clk);
  endtask
  // ----
  // Listener, samples mid-bit
  // ----
  always begin
    @(negedge txd);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      sh[i] = txd;
    end
    repeat (BIT) @(posedge clk);
    fe_q.push_back(!txd);
    got_q.push_back(sh);
  end
endmodule // ulf_lin_node
`default_nettype wire

// >>> verif/test_uart_lin_fifo_stop_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_uart_lin_fifo_stop_control;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic rx_line, tx_line, rx_irq, tx_irq, fe_irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, slv;
  int err_count, checked;
  ulf_uart_lin i_dut (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_IN(rx_line), .TX_OUT(tx_line), .RX_READY_IRQ(rx_irq), .TX_READY_IRQ(tx_irq),
    .FRAMING_ERR_IRQ(fe_irq));
  ulf_lin_node #(.BIT(16)) i_node (.clk(clk), .txd(tx_line), .rxd(rx_line));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----
  // Report and bus
  // ----
  task automatic summarize;
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    err_count++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    summarize();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) hang();
    rd = prdata;
    slv = 32'(pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // Checks the node's received byte count before each edge, for at most 4000 edges
  task automatic wait_rx(input int n);
    for (int k = 0; k < 4000 && i_node.got_q.size() < n; k++) @(posedge clk);
    if (i_node.got_q.size() < n) hang();
  endtask
  // Header holds the PID in the shift register for break plus sync, so allow a long wait
  task automatic wait_tx;
    for (int k = 0; k < 2000; k++) begin
      @(posedge clk);
      if (tx_irq === 1'b1) break;
    end
    if (tx_irq !== 1'b1) hang();
  endtask
  function automatic logic [7:0] csum(input logic [7:0] s, input logic [7:0] b);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, b};
    return t[7:0] + {7'h0, t[8]};
  endfunction
  // ----
  // Scenarios
  // ----
  task automatic s_reset;
    rdchk(8'h00, 32'h0);
    rdchk(8'h04, 32'h364);
    rdchk(8'h08, 32'h5);
    rdchk(8'h0C, 32'h0);
    apb(1'b1, 8'h18, 32'hFFFFFFFF);
    rdchk(8'h18, 32'h1);
    chk(slv, 32'h0);
    apb(1'b1, 8'h40, 32'h1);
    chk(slv, 32'h1);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h04, 32'h10);
  endtask
  task automatic s_rxbuf;
    apb(1'b1, 8'h00, 32'h807);
    i_node.send(8'hA1, 1'b1, 1'b1);
    i_node.send(8'h5C, 1'b1, 1'b1);
    i_node.send(8'h33, 1'b1, 1'b1);
    rdchk(8'h08, 32'h206);
    rdchk(8'h0C, 32'hA1);
    rdchk(8'h0C, 32'h5C);
    apb(1'b1, 8'h08, 32'h200);
    i_node.send(8'h7E, 1'b1, 1'b1);
    rdchk(8'h0C, 32'h7E);
    i_node.send(8'h11, 1'b1, 1'b1);
    apb(1'b1, 8'h08, 32'h1);
    rdchk(8'h08, 32'h5);
  endtask
  task automatic s_delay;
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 8'h08, {26'h0, m[0], 5'h1});
      fork
        i_node.send(8'h42, 1'b1, 1'b1);
        begin
          repeat (159) @(posedge clk);
          chk(32'(rx_irq), 32'(!m[0]));
        end
      join
    end
    apb(1'b1, 8'h08, 32'h1);
  endtask
  task automatic s_frame;
    logic [4:0] t [4];
    t = '{5'b00011, 5'b10101, 5'b01011, 5'b11100};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h00, {22'h0, t[i][4:3], 8'h07});
      i_node.send(8'h3C, t[i][2], t[i][1]);
      apb(1'b0, 8'h08, 32'h0);
      chk(32'(rd[6]), 32'(t[i][0]));
      chk(32'(fe_irq), 32'(t[i][0]));
      // Low second stops are sent only in the two-stop settings, where they stay inside the frame; let the line idle
      repeat (200) @(posedge clk);
      apb(1'b1, 8'h08, 32'h41);
    end
  endtask
  task automatic s_tx;
    apb(1'b1, 8'h00, 32'h5);
    apb(1'b1, 8'h10, 32'hC3);
    rdchk(8'h08, 32'h5);
    apb(1'b1, 8'h10, 32'h96);
    apb(1'b1, 8'h10, 32'h0F);
    rdchk(8'h08, 32'h19);
    chk(32'(tx_irq), 32'h0);
    chk(i_node.got_q.size(), 32'h0);
    apb(1'b1, 8'h00, 32'h7);
    wait_rx(2);
    chk(i_node.got_q.pop_front(), 32'hC3);
    chk(i_node.got_q.pop_front(), 32'h96);
    apb(1'b1, 8'h08, 32'h10);
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, 8'h00, 32'h5);
      apb(1'b1, 8'h10, 32'hAA);
      apb(1'b1, 8'h10, 32'hBB);
      apb(1'b1, j ? 8'h08 : 8'h00, j ? 32'h4 : 32'h0);
      apb(1'b1, 8'h00, 32'h7);
      repeat (400) @(posedge clk);
      chk(i_node.got_q.size(), 32'h0);
    end
  endtask
  task automatic s_lin;
    logic [7:0] d [3];
    logic [7:0] s;
    d = '{8'h8D, 8'h12, 8'hF0};
    for (int m = 0; m < 2; m++) begin
      i_node.got_q.delete();
      i_node.fe_q.delete();
      apb(1'b1, 8'h14, 32'h2);
      apb(1'b1, 8'h00, {21'h0, m[0], 10'h0C6});
      apb(1'b1, 8'h00, {21'h0, m[0], 10'h0C7});
      s = csum(csum(m ? d[0] : 8'h0, d[1]), d[2]);
      for (int i = 0; i < 3; i++) begin
        wait_tx();
        apb(1'b1, 8'h10, {24'h0, d[i]});
      end
      wait_rx(6);
      chk(i_node.got_q.pop_front(), 32'h0);
      chk(32'(i_node.fe_q[0]), 32'h1);
      chk(i_node.got_q.pop_front(), 32'h55);
      for (int i = 0; i < 3; i++) chk(i_node.got_q.pop_front(), {24'h0, d[i]});
      chk(i_node.got_q.pop_front(), {24'h0, ~s});
      chk(32'(tx_line), 32'h1);
    end
  endtask
  task automatic s_lrx;
    logic [7:0] b [6];
    b = '{8'h00, 8'h55, 8'h8D, 8'h12, 8'hF0, 8'h00};
    for (int m = 0; m < 2; m++) begin
      b[5] = ~csum(csum(b[2], b[3]), b[4]) ^ 8'(m);
      for (int i = 0; i < 6; i++) begin
        i_node.send(b[i], i != 0, 1'b1);
        apb(1'b0, 8'h0C, 32'h0);
        if (i != 0) chk(rd, {24'h0, b[i]});
      end
      apb(1'b0, 8'h08, 32'h0);
      chk(32'(rd[8]), 32'(m));
      apb(1'b1, 8'h08, 32'h141);
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    err_count = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    s_reset();
    s_rxbuf();
    s_delay();
    s_frame();
    s_tx();
    s_lin();
    s_lrx();
    summarize();
  end
  initial begin
    repeat (90000) @(posedge clk);
    hang();
  end
endmodule // test_uart_lin_fifo_stop_control
`default_nettype wire
